//--- rtl/flash_prog_regs.svh
// Purpose: constants for the flash program host controller
// Assumes: x16 flash, word addressing, 50 MHz clock
// Notes: none
`ifndef FLASH_PROG_REGS_SVH
`define FLASH_PROG_REGS_SVH
`define UNLOCK1_ADDR 26'h0000555
`define UNLOCK1_DATA 16'h00AA
`define UNLOCK2_ADDR 26'h00002AA
`define UNLOCK2_DATA 16'h0055
`define PROG_SETUP_DEFAULT 16'h00A0
`define CLK_PERIOD_NS 32'd20
`define WR_PULSE_NS 32'd40
`define WR_PULSE_CYC ((`WR_PULSE_NS + `CLK_PERIOD_NS - 32'd1) / `CLK_PERIOD_NS)
`define RESET_PULSE_NS 32'd500
`define RESET_PULSE_CYC ((`RESET_PULSE_NS + `CLK_PERIOD_NS - 32'd1) / `CLK_PERIOD_NS)
`define RESET_RECOVERY_NS 32'd35000
`define RESET_RECOVERY_CYC ((`RESET_RECOVERY_NS + `CLK_PERIOD_NS - 32'd1) / `CLK_PERIOD_NS)
`define TIMER_W 16
`endif

//--- rtl/flash_prog_pkg.sv
// Purpose: types for the flash program host controller
// Assumes: x16 data bus, 26-bit word address
// Notes: none
package flash_prog_pkg;
    typedef logic [25:0] addr_t;
    typedef logic [15:0] word_t;
    typedef struct packed {
        addr_t addr;
        word_t data;
        logic no_unlock;
    } prog_req_s;
    typedef struct packed {
        addr_t addr;
        word_t dq_out;
        logic dq_oe_n;
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic reset_n;
    } flash_pins_s;
    typedef enum logic [2:0] {
        ST_IDLE, ST_CYCLE, ST_BUSY, ST_HWRST, ST_RECOVER
    } ctl_state_e;
endpackage : flash_prog_pkg

//--- rtl/bus_write_cycle.sv
// Purpose: one asynchronous write cycle on the flash pins
// Assumes: address and data held by caller during the cycle
// Notes: we_n low for a fixed number of clocks
`timescale 1ns/100ps
`default_nettype none
`include "flash_prog_regs.svh"
module bus_write_cycle
    import flash_prog_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    output logic we_n,
    output logic done
);
    logic [`TIMER_W-1:0] cnt_ff;
    logic [`TIMER_W-1:0] nxt_cnt;
    logic act_ff;
    logic nxt_act;
    logic done_ff;
    logic nxt_done;

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_act = act_ff;
        nxt_done = 1'b0;
        if (start && !act_ff) begin
            nxt_act = 1'b1;
            nxt_cnt = `TIMER_W'(`WR_PULSE_CYC);
        end else if (act_ff) begin
            if (cnt_ff == `TIMER_W'(1)) begin
                nxt_act = 1'b0;
                nxt_done = 1'b1;
            end
            nxt_cnt = cnt_ff - `TIMER_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff <= '0;
            act_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            act_ff <= nxt_act;
            done_ff <= nxt_done;
        end
    end

    assign we_n = ~act_ff;
    assign done = done_ff;
endmodule : bus_write_cycle
`default_nettype wire

//--- rtl/flash_program_ecc_control.sv
// Purpose: host side controller issuing word program sequences to a parallel NOR flash
// Assumes: inputs synchronous to clk; ready_busy_output sampled directly
// Notes: the flash keeps its own per-page ecc; this side only sequences commands
// Function
// - word program is four write cycles
// - host reissues interrupted program after reset; the controller only raises retry_needed and waits for a new request
// - overlays use program without unlock writes
// - host should program each page once
// - first unlock writes AA at 555
// - second unlock writes 55 at 2AA
`timescale 1ns/100ps
`default_nettype none
`include "flash_prog_regs.svh"
module flash_program_ecc_control
    import flash_prog_pkg::*;
#(
    parameter word_t PROG_SETUP_CODE = `PROG_SETUP_DEFAULT,
    parameter int RECOVERY_CYC = `RESET_RECOVERY_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    output logic req_ready,
    input wire prog_req_s req,
    input wire logic hw_reset_req,
    output logic busy,
    output logic done,
    output logic retry_needed,
    input wire logic ready_busy_output,
    output flash_pins_s pins
);
    // ------------------------------------------------------------
    // sequencer state and write cycle datapath
    // ------------------------------------------------------------
    ctl_state_e state_ff, nxt_state;
    logic [1:0] step_ff, nxt_step;
    prog_req_s req_ff, nxt_req;
    logic [`TIMER_W-1:0] tmr_ff, nxt_tmr;
    logic seen_busy_ff, nxt_seen_busy;
    logic done_ff, nxt_done;
    logic retry_ff, nxt_retry;
    logic cyc_start;
    logic cyc_done;
    logic we_n;
    addr_t cyc_addr;
    word_t cyc_data;

    // ------------------------------------------------------------
    // write strobe timing
    // ------------------------------------------------------------
    bus_write_cycle u_cycle (
        .clk(clk),
        .rst(rst),
        .start(cyc_start),
        .we_n(we_n),
        .done(cyc_done)
    );

    // ------------------------------------------------------------
    // address and data of the current write cycle
    // ------------------------------------------------------------
    always_comb begin
        case (step_ff)
            2'd0: begin
                cyc_addr = `UNLOCK1_ADDR;
                cyc_data = `UNLOCK1_DATA;
            end
            2'd1: begin
                cyc_addr = `UNLOCK2_ADDR;
                cyc_data = `UNLOCK2_DATA;
            end
            2'd2: begin
                cyc_addr = req_ff.addr;
                cyc_data = PROG_SETUP_CODE;
            end
            default: begin
                cyc_addr = req_ff.addr;
                cyc_data = req_ff.data;
            end
        endcase
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_step = step_ff;
        nxt_req = req_ff;
        nxt_tmr = tmr_ff;
        nxt_seen_busy = seen_busy_ff;
        nxt_done = 1'b0;
        nxt_retry = retry_ff;
        cyc_start = 1'b0;
        // a reset request while already resetting or recovering is ignored
        if (hw_reset_req && state_ff != ST_HWRST && state_ff != ST_RECOVER) begin
            // abort whatever runs; an interrupted program must be redone
            nxt_retry = (state_ff == ST_CYCLE) || (state_ff == ST_BUSY);
            nxt_state = ST_HWRST;
            nxt_tmr = `TIMER_W'(`RESET_PULSE_CYC);
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (req_valid) begin
                        // one program per request; a page is never rewritten on its own
                        nxt_req = req;
                        nxt_retry = 1'b0;
                        nxt_step = req.no_unlock ? 2'd2 : 2'd0;
                        nxt_state = ST_CYCLE;
                    end
                end
                ST_CYCLE: begin
                    cyc_start = 1'b1;
                    if (cyc_done) begin
                        cyc_start = 1'b0;
                        if (step_ff == 2'd3) begin
                            nxt_state = ST_BUSY;
                            nxt_seen_busy = 1'b0;
                            nxt_tmr = `TIMER_W'(`WR_PULSE_CYC);
                        end else begin
                            nxt_step = step_ff + 2'd1;
                        end
                    end
                end
                ST_BUSY: begin
                    // no commands issued while the flash runs its algorithm
                    // ready may drop late after the last write; the timer bridges that gap
                    if (tmr_ff != '0) begin
                        nxt_tmr = tmr_ff - `TIMER_W'(1);
                    end
                    if (!ready_busy_output) begin
                        nxt_seen_busy = 1'b1;
                    end
                    if (ready_busy_output && (seen_busy_ff || tmr_ff == '0)) begin
                        nxt_state = ST_IDLE;
                        nxt_done = 1'b1;
                    end
                end
                ST_HWRST: begin
                    // reset pin held low for the pulse width
                    if (tmr_ff == '0) begin
                        nxt_state = ST_RECOVER;
                        nxt_tmr = `TIMER_W'(RECOVERY_CYC);
                    end else begin
                        nxt_tmr = tmr_ff - `TIMER_W'(1);
                    end
                end
                ST_RECOVER: begin
                    // flash takes no commands until recovery ends
                    if (tmr_ff == '0) begin
                        nxt_state = ST_IDLE;
                    end else begin
                        nxt_tmr = tmr_ff - `TIMER_W'(1);
                    end
                end
                default: begin
                    nxt_state = ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            step_ff <= 2'd0;
            req_ff <= '0;
            tmr_ff <= '0;
            seen_busy_ff <= 1'b0;
            done_ff <= 1'b0;
            retry_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            step_ff <= nxt_step;
            req_ff <= nxt_req;
            tmr_ff <= nxt_tmr;
            seen_busy_ff <= nxt_seen_busy;
            done_ff <= nxt_done;
            retry_ff <= nxt_retry;
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    logic in_cycle;
    assign in_cycle = (state_ff == ST_CYCLE);
    assign req_ready = (state_ff == ST_IDLE) && !hw_reset_req;
    assign busy = (state_ff != ST_IDLE);
    assign done = done_ff;
    assign retry_needed = retry_ff;
    assign pins.addr = in_cycle ? cyc_addr : req_ff.addr;
    assign pins.dq_out = in_cycle ? cyc_data : '0;
    assign pins.dq_oe_n = ~in_cycle;
    assign pins.ce_n = ~in_cycle;
    assign pins.we_n = in_cycle ? we_n : 1'b1;
    assign pins.oe_n = 1'b1;
    // reset pin low only during the pulse, high again through recovery
    assign pins.reset_n = (state_ff != ST_HWRST);
endmodule : flash_program_ecc_control
`default_nettype wire

//--- verif/flash_prog_chk.sv
// Purpose: port checker for flash_program_ecc_control
// Assumes: one clock, sync reset
// Notes: bound to the controller
`timescale 1ns/100ps
`default_nettype none
`include "flash_prog_regs.svh"
module flash_prog_chk
    import flash_prog_pkg::*;
#(
    parameter word_t PROG_SETUP_CODE = `PROG_SETUP_DEFAULT,
    parameter int RECOVERY_CYC = 5
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire prog_req_s req,
    input wire logic hw_reset_req,
    input wire logic busy,
    input wire logic done,
    input wire logic retry_needed,
    input wire logic ready_busy_output,
    input wire flash_pins_s pins
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire logic take = req_valid && req_ready;
    sequence s_unl1;
        $fell(pins.we_n) && pins.addr == `UNLOCK1_ADDR && pins.dq_out == `UNLOCK1_DATA;
    endsequence
    sequence s_unl2;
        $fell(pins.we_n) && pins.addr == `UNLOCK2_ADDR && pins.dq_out == `UNLOCK2_DATA;
    endsequence
    AST_UNLOCK1: assert property (take && !req.no_unlock |=> !pins.ce_n && !pins.dq_oe_n && pins.addr == `UNLOCK1_ADDR)
        else $error("first unlock write wrong");
    AST_UNLOCK2: assert property (s_unl1 |-> ##[1:6] s_unl2) else $error("second unlock write missing");
    AST_OVERLAY: assert property (take && req.no_unlock |=> pins.dq_out == PROG_SETUP_CODE)
        else $error("overlay setup write wrong");
    AST_WE_PULSE: assert property ($fell(pins.we_n) |=> !pins.we_n && $stable(pins.addr) ##1 pins.we_n)
        else $error("write strobe wrong");
    AST_READY: assert property (req_ready == (!busy && !hw_reset_req)) else $error("ready wrong");
    AST_DONE: assert property (done |-> $past(ready_busy_output) ##1 !done) else $error("done wrong");
    AST_HWRST: assert property ($rose(hw_reset_req) && !busy |-> ##[1:2] !pins.reset_n)
        else $error("reset pin not driven");
    AST_RETRY: assert property (take |=> !retry_needed) else $error("retry not cleared");
    AST_ABORT: assert property ($rose(retry_needed) |-> !pins.reset_n && pins.ce_n && pins.we_n)
        else $error("abort did not pull reset low");
endmodule : flash_prog_chk
bind flash_program_ecc_control flash_prog_chk #(.PROG_SETUP_CODE(PROG_SETUP_CODE), .RECOVERY_CYC(RECOVERY_CYC)) chk (
    .clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req(req), .hw_reset_req(hw_reset_req),
    .busy(busy), .done(done), .retry_needed(retry_needed), .ready_busy_output(ready_busy_output), .pins(pins));
`default_nettype wire

//--- verif/flash_dev_model.sv
// Purpose: behavioural flash answering word program sequences
// Assumes: writes latched at the rising edge of we_n
// Notes: erased words read as FFFF
`timescale 1ns/100ps
`default_nettype none
`include "flash_prog_regs.svh"
module flash_dev_model
    import flash_prog_pkg::*;
#(
    parameter word_t SETUP_CODE = `PROG_SETUP_DEFAULT
) (
    input wire logic clk,
    input wire flash_pins_s pins,
    input wire logic overlay,
    input wire logic [7:0] busy_cyc,
    output logic ready_busy_output
);
    word_t mem [addr_t];
    // per 32-byte page: programmed once, and correction switched off
    bit pg_used [logic [21:0]];
    bit pg_ecc_off [logic [21:0]];
    logic [1:0] step = 2'h0;
    logic [7:0] cnt = 8'h00;
    logic we_q = 1'b1;
    addr_t pa;
    word_t pd;
    function automatic word_t rd(input addr_t a);
        return mem.exists(a) ? mem[a] : 16'hFFFF;
    endfunction : rd
    function automatic logic ecc_on(input addr_t a);
        return !pg_ecc_off.exists(a[25:4]);
    endfunction : ecc_on
    assign ready_busy_output = (cnt == 8'h00);
    always @(posedge clk) begin
        we_q <= pins.we_n;
        if (!pins.reset_n) begin
            cnt <= 8'h00;
            step <= 2'h0;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
            if (cnt == 8'h01) begin
                mem[pa] = rd(pa) & pd;
                if (pg_used.exists(pa[25:4])) pg_ecc_off[pa[25:4]] = 1'b1;
                pg_used[pa[25:4]] = 1'b1;
            end
        end else if (pins.we_n && !we_q && !pins.ce_n) begin
            step <= 2'h0;
            if (step == 2'h0 && pins.addr == `UNLOCK1_ADDR && pins.dq_out == `UNLOCK1_DATA) step <= 2'h1;
            if (step == 2'h0 && overlay && pins.dq_out == SETUP_CODE) step <= 2'h3;
            if (step == 2'h1 && pins.addr == `UNLOCK2_ADDR && pins.dq_out == `UNLOCK2_DATA) step <= 2'h2;
            if (step == 2'h2 && pins.dq_out == SETUP_CODE) step <= 2'h3;
            if (step == 2'h3) begin
                pa <= pins.addr;
                pd <= pins.dq_out;
                cnt <= busy_cyc;
            end
        end
    end
endmodule : flash_dev_model
`default_nettype wire

//--- verif/flash_program_ecc_control_tb.sv
// Purpose: self-checking bench for flash_program_ecc_control
// Assumes: flash model drives the ready/busy pin
// Notes: recovery shortened to 5 cycles
`timescale 1ns/100ps
`default_nettype none
module flash_program_ecc_control_tb
    import flash_prog_pkg::*;
;
    logic clk = 1'b0;
    logic rst;
    logic req_valid;
    logic hw_reset_req;
    logic overlay;
    logic [7:0] busy_cyc;
    prog_req_s req;
    logic req_ready, busy, done, retry_needed, rdy;
    flash_pins_s pins;
    int num_errors = 0;
    int n_checks = 0;
    always #10 clk = ~clk;
    flash_program_ecc_control #(.RECOVERY_CYC(5)) uut (.clk(clk), .rst(rst), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .hw_reset_req(hw_reset_req), .busy(busy), .done(done),
        .retry_needed(retry_needed), .ready_busy_output(rdy), .pins(pins));
    flash_dev_model dev (.clk(clk), .pins(pins), .overlay(overlay), .busy_cyc(busy_cyc), .ready_busy_output(rdy));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input word_t seen, input word_t exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wait_for(input int which, input int lim);
        int i;
        logic hit;
        hit = 1'b0;
        for (i = 0; i < lim && !hit; i++) begin
            // sample at the falling edge: the value the next rising edge will see
            @(negedge clk);
            hit = (which == 0 && done === 1'b1) || (which == 1 && req_ready === 1'b1)
                || (which == 2 && rdy === 1'b0);
            @(posedge clk);
        end
        if (!hit) begin
            num_errors++;
            tally_and_finish();
        end
    endtask : wait_for
    task automatic prog(input addr_t a, input word_t d, input logic nu);
        req_valid <= 1'b1;
        req <= '{addr: a, data: d, no_unlock: nu};
        wait_for(1, 50);
        req_valid <= 1'b0;
    endtask : prog
    task automatic hwrst();
        hw_reset_req <= 1'b1;
        @(posedge clk);
        hw_reset_req <= 1'b0;
        @(posedge clk);
        wait_for(1, 100);
    endtask : hwrst
    task automatic t_word();
        prog(26'h1234567, 16'hFF0F, 1'b0);
        @(posedge clk);
        chk(req_ready, 16'h0000);
        chk(busy, 16'h0001);
        wait_for(0, 500);
        chk(dev.rd(26'h1234567), 16'hFF0F);
        chk(dev.ecc_on(26'h1234567), 16'h0001);
        chk(busy, 16'h0000);
        busy_cyc <= 8'h02;
        prog(26'h1234567, 16'h0FF0, 1'b0);
        wait_for(0, 500);
        chk(dev.rd(26'h1234567), 16'h0F00);
        chk(dev.ecc_on(26'h1234567), 16'h0000);
        $display("word program test done");
    endtask : t_word
    task automatic t_overlay();
        overlay <= 1'b1;
        prog(26'h0000040, 16'h1234, 1'b1);
        wait_for(0, 500);
        chk(dev.rd(26'h0000040), 16'h1234);
        overlay <= 1'b0;
        $display("overlay program test done");
    endtask : t_overlay
    task automatic t_abort();
        hwrst();
        chk(retry_needed, 16'h0000);
        busy_cyc <= 8'hC8;
        prog(26'h0000100, 16'h00FF, 1'b0);
        wait_for(2, 100);
        hwrst();
        chk(retry_needed, 16'h0001);
        chk(dev.rd(26'h0000100), 16'hFFFF);
        busy_cyc <= 8'h04;
        prog(26'h0000100, 16'h00FF, 1'b0);
        wait_for(0, 500);
        chk(retry_needed, 16'h0000);
        chk(dev.rd(26'h0000100), 16'h00FF);
        $display("reset abort test done");
    endtask : t_abort
    initial begin
        rst <= 1'b1;
        req_valid <= 1'b0;
        hw_reset_req <= 1'b0;
        overlay <= 1'b0;
        busy_cyc <= 8'h14;
        req <= '0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_word();
        t_overlay();
        t_abort();
        tally_and_finish();
    end
endmodule : flash_program_ecc_control_tb
`default_nettype wire
